// ==== adcs_cfg_props.sv ====
// port assertions of the configuration register bank
`timescale 1ns/10ps
module adcs_cfg_props (
  // clock and reset
  input wire        clk,
  input wire        srst,
  input wire        ce,
  // register port
  input wire [8:0]  reg_addr,
  input wire        reg_wr,
  input wire [7:0]  reg_wdata,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata_ff,
  // sync and outputs
  input wire        sync_pin,
  input wire        divider_sync_pulse_ff,
  input wire [15:0] user_pattern_one,
  input wire [15:0] user_pattern_two,
  input wire        overrange_pin_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_wr(a);
    ce && reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(a);
    ce && reg_rd && reg_addr == a;
  endsequence
  AST_RESET: assert property (disable iff (1'b0) srst && ce |=>
    user_pattern_one == 16'h0000 && user_pattern_two == 16'h0000 && overrange_pin_en)
    else $error("reset values wrong");
  AST_PAT1_LO: assert property (s_wr(9'h019) |=> user_pattern_one[7:0] == $past(reg_wdata))
    else $error("pattern one low byte not loaded");
  AST_PAT1_HI: assert property (s_wr(9'h01a) |=> user_pattern_one[15:8] == $past(reg_wdata))
    else $error("pattern one high byte not loaded");
  AST_PAT2_LO: assert property (s_wr(9'h01b) |=> user_pattern_two[7:0] == $past(reg_wdata))
    else $error("pattern two low byte not loaded");
  AST_PAT2_HI: assert property (s_wr(9'h01c) |=> user_pattern_two[15:8] == $past(reg_wdata))
    else $error("pattern two high byte not loaded");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");
  AST_RD_SYNC: assert property (s_rd(9'h100) |=> reg_rdata_ff[7:3] == 5'h00)
    else $error("open sync bits read nonzero");
  AST_RD_SIG: assert property (s_rd(9'h024) |=> reg_rdata_ff[7:1] == 7'h00)
    else $error("open signature bits read nonzero");
  AST_RD_UNMAP: assert property (s_rd(9'h018) |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read nonzero");
  AST_PULSE_ONE: assert property (divider_sync_pulse_ff |=> !divider_sync_pulse_ff)
    else $error("sync pulse longer than one cycle");
  AST_PULSE_CAUSE: assert property (divider_sync_pulse_ff |->
    $past(sync_pin, 3) && !$past(sync_pin, 4)) else $error("sync pulse without sync input");
endmodule

bind adcs_cfg_regs adcs_cfg_props i_adcs_cfg_props (.clk(clk), .srst(srst), .ce(ce),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .sync_pin(sync_pin),
  .divider_sync_pulse_ff(divider_sync_pulse_ff), .user_pattern_one(user_pattern_one),
  .user_pattern_two(user_pattern_two), .overrange_pin_en(overrange_pin_en));

// ==== adcs_cfg_regs.v ====
// output, pattern, sync and misc configuration registers of the dual converter
`timescale 1ns/10ps
`include "adcs_regs.vh"

module adcs_cfg_regs #(
  parameter CHANNEL_B = 1'b0
) (
  // clock, reset, clock enable
  input  wire       clk,
  input  wire       srst,
  input  wire       ce,
  // register port from the serial port engine
  input  wire [8:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_ff,
  // core status
  input  wire       signature_bit,
  input  wire       div_phase,
  input  wire       sync_pin,
  input  wire       low_rate_pin,
  // configuration outputs
  output wire       output_data_clock_phase,
  output wire       output_data_clock_invert,
  output wire       dco_delay_en,
  output wire       data_delay_en,
  output wire [2:0] fine_delay_code,
  output wire [15:0] user_pattern_one,
  output wire [15:0] user_pattern_two,
  output wire       overrange_pin_en,
  output wire       channel_core_sel,
  output reg        divider_sync_pulse_ff,
  output wire       output_enable_bar_pin_en,
  output wire       low_rate_oscillator_on,
  output wire       sdio_pulldown_disable
);
  reg [7:0] clk_phase_ff;
  reg [7:0] fine_delay_ff;
  reg [7:0] pat1_lo_ff;
  reg [7:0] pat1_hi_ff;
  reg [7:0] pat2_lo_ff;
  reg [7:0] pat2_hi_ff;
  reg [7:0] ovr_feat_ff;
  reg [7:0] ch_assign_ff;
  reg [7:0] sync_ctrl_ff;
  reg [7:0] user_misc_ff;
  reg       sync_meta_ff;
  reg       sync_sync_ff;
  reg       sync_prev_ff;
  reg       low_meta_ff;
  reg       low_sync_ff;
  reg       sig_meta_ff;
  reg       sig_sync_ff;
  reg [7:0] nxt_rdata;
  reg [7:0] nxt_sync_ctrl;
  reg       nxt_sync_pulse;

  wire sel_wr_sync;
  wire sync_edge;
  wire sync_gate;
  wire osc_forced;
  wire osc_detected;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      sync_meta_ff <= 1'b0;
      sync_sync_ff <= 1'b0;
      sync_prev_ff <= 1'b0;
      low_meta_ff  <= 1'b0;
      low_sync_ff  <= 1'b0;
      sig_meta_ff  <= 1'b0;
      sig_sync_ff  <= 1'b0;
    end else if (ce) begin
      sync_meta_ff <= sync_pin;
      sync_sync_ff <= sync_meta_ff;
      sync_prev_ff <= sync_sync_ff;
      low_meta_ff  <= low_rate_pin;
      low_sync_ff  <= low_meta_ff;
      sig_meta_ff  <= signature_bit;
      sig_sync_ff  <= sig_meta_ff;
    end
  end

  // the edge detector resets low, the idle level of the sync pin, so no edge follows reset
  assign sync_edge = sync_sync_ff & ~sync_prev_ff;

  // ----------------------------------------------------------------------------
  // sync control
  // ----------------------------------------------------------------------------
  // a pulse that arrives while the gate is closed is dropped, not held for later
  assign sel_wr_sync = reg_wr & (reg_addr == `ADCS_OFS_SYNC_CTRL);
  // master and divider enables both needed before any pulse passes
  assign sync_gate = sync_ctrl_ff[`ADCS_SYNC_MASTER_BIT] & sync_ctrl_ff[`ADCS_SYNC_DIV_BIT];

  always @* begin
    nxt_sync_ctrl  = sync_ctrl_ff;
    nxt_sync_pulse = sync_gate & sync_edge;
    if (sel_wr_sync) begin
      nxt_sync_ctrl = reg_wdata & `ADCS_MSK_SYNC_CTRL;
    end
    // one-shot: the hardware clear wins, so a pulse in the write cycle is honoured once
    if (nxt_sync_pulse & sync_ctrl_ff[`ADCS_SYNC_NEXT_BIT]) begin
      nxt_sync_ctrl[`ADCS_SYNC_DIV_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------------
  // the sync register goes through nxt_sync_ctrl so that its hardware clear can win
  always @(posedge clk) begin
    if (srst) begin
      clk_phase_ff          <= `ADCS_RST_ZERO;
      fine_delay_ff         <= `ADCS_RST_ZERO;
      pat1_lo_ff            <= `ADCS_RST_ZERO;
      pat1_hi_ff            <= `ADCS_RST_ZERO;
      pat2_lo_ff            <= `ADCS_RST_ZERO;
      pat2_hi_ff            <= `ADCS_RST_ZERO;
      ovr_feat_ff           <= `ADCS_RST_OVR_FEAT;
      ch_assign_ff          <= {7'h00, CHANNEL_B[0]};
      sync_ctrl_ff          <= `ADCS_RST_SYNC_CTRL;
      user_misc_ff          <= `ADCS_RST_USER_MISC;
      divider_sync_pulse_ff <= 1'b0;
    end else if (ce) begin
      sync_ctrl_ff          <= nxt_sync_ctrl;
      divider_sync_pulse_ff <= nxt_sync_pulse;
      if (reg_wr) begin
        case (reg_addr)
          `ADCS_OFS_CLK_PHASE:  clk_phase_ff  <= reg_wdata & `ADCS_MSK_CLK_PHASE;
          `ADCS_OFS_FINE_DELAY: fine_delay_ff <= reg_wdata & `ADCS_MSK_FINE_DELAY;
          `ADCS_OFS_PAT1_LO:    pat1_lo_ff    <= reg_wdata;
          `ADCS_OFS_PAT1_HI:    pat1_hi_ff    <= reg_wdata;
          `ADCS_OFS_PAT2_LO:    pat2_lo_ff    <= reg_wdata;
          `ADCS_OFS_PAT2_HI:    pat2_hi_ff    <= reg_wdata;
          `ADCS_OFS_OVR_FEAT:   ovr_feat_ff   <= reg_wdata & `ADCS_MSK_ONE_BIT;
          `ADCS_OFS_CH_ASSIGN:  ch_assign_ff  <= reg_wdata & `ADCS_MSK_ONE_BIT;
          `ADCS_OFS_USER_MISC:  user_misc_ff  <= reg_wdata & `ADCS_MSK_USER_MISC;
          // writes to the read-only signature offset fall through here
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------------
  always @* begin
    nxt_rdata = `ADCS_RST_ZERO;
    case (reg_addr)
      `ADCS_OFS_CLK_PHASE:  nxt_rdata = clk_phase_ff;
      `ADCS_OFS_FINE_DELAY: nxt_rdata = fine_delay_ff;
      `ADCS_OFS_PAT1_LO:    nxt_rdata = pat1_lo_ff;
      `ADCS_OFS_PAT1_HI:    nxt_rdata = pat1_hi_ff;
      `ADCS_OFS_PAT2_LO:    nxt_rdata = pat2_lo_ff;
      `ADCS_OFS_PAT2_HI:    nxt_rdata = pat2_hi_ff;
      `ADCS_OFS_SIGNATURE:  nxt_rdata = {7'h00, sig_sync_ff};
      `ADCS_OFS_OVR_FEAT:   nxt_rdata = ovr_feat_ff;
      `ADCS_OFS_CH_ASSIGN:  nxt_rdata = ch_assign_ff;
      `ADCS_OFS_SYNC_CTRL:  nxt_rdata = sync_ctrl_ff;
      `ADCS_OFS_USER_MISC:  nxt_rdata = user_misc_ff;
      default:              nxt_rdata = `ADCS_RST_ZERO;
    endcase
  end

  // registered read data: the host shifts it out after the read strobe
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata_ff <= `ADCS_RST_ZERO;
    end else if (ce && reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // output clock phase
  // ----------------------------------------------------------------------------
  // only the output clock path is delayed; sampling keeps the raw divider
  adcs_phase_sel #(
    .DEPTH (`ADCS_PHASE_CODES)
  ) u_phase (
    .clk          (clk),
    .srst         (srst),
    .ce           (ce),
    .div_phase    (div_phase),
    .phase_sel    (clk_phase_ff[`ADCS_PHASE_MSB:`ADCS_PHASE_LSB]),
    .phase_out_ff (output_data_clock_phase)
  );

  // ----------------------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------------------
  assign output_data_clock_invert = clk_phase_ff[`ADCS_DCO_INV_BIT];
  assign dco_delay_en             = fine_delay_ff[`ADCS_DLY_DCO_BIT];
  assign data_delay_en            = fine_delay_ff[`ADCS_DLY_DATA_BIT];
  assign fine_delay_code          = fine_delay_ff[`ADCS_DLY_MSB:`ADCS_DLY_LSB];
  assign user_pattern_one         = {pat1_hi_ff, pat1_lo_ff};
  assign user_pattern_two         = {pat2_hi_ff, pat2_lo_ff};
  assign overrange_pin_en         = ovr_feat_ff[`ADCS_OVR_EN_BIT];
  assign channel_core_sel         = ch_assign_ff[`ADCS_ASSIGN_BIT];
  assign output_enable_bar_pin_en = user_misc_ff[`ADCS_MISC_OEB_BIT];
  assign sdio_pulldown_disable    = user_misc_ff[`ADCS_MISC_PD_BIT];
  assign osc_forced               = user_misc_ff[`ADCS_MISC_RUN_BIT];
  assign osc_detected             = user_misc_ff[`ADCS_MISC_DET_BIT] & low_sync_ff;
  // the detector cannot be trusted near its threshold, so the run bit overrides it
  assign low_rate_oscillator_on   = osc_forced | osc_detected;
endmodule

// ==== adcs_cfg_regs_tb.sv ====
// self-checking bench of the configuration register bank
`timescale 1ns/10ps
module adcs_cfg_regs_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        sig_bit = 1'b0;
  logic        div_phase = 1'b0;
  logic        sync_pin = 1'b0;
  logic        low_rate_pin = 1'b0;
  wire  [8:0]  reg_addr;
  wire  [7:0]  reg_wdata;
  wire  [7:0]  reg_rdata_ff;
  wire         reg_wr;
  wire         reg_rd;
  wire         phase_out;
  wire         pulse;
  wire         osc_on;
  wire  [15:0] pat_one;
  wire  [15:0] pat_two;
  wire  [9:0]  cfg_out;
  logic [7:0]  d;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  // reset value and readable mask per offset; 0x018 is unmapped
  logic [8:0]  addr_t [12] = '{9'h016, 9'h017, 9'h019, 9'h01a, 9'h01b, 9'h01c, 9'h024,
                               9'h02a, 9'h02e, 9'h100, 9'h101, 9'h018};
  logic [7:0]  rst_t [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                              8'h00, 8'h01, 8'h88, 8'h00};
  logic [7:0]  msk_t [12] = '{8'h87, 8'ha7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h01,
                              8'h01, 8'h07, 8'h8d, 8'h00};
  adcs_cfg_regs #(.CHANNEL_B(1'b0)) i_adcs_cfg_regs (.clk(clk), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .signature_bit(sig_bit), .div_phase(div_phase),
    .sync_pin(sync_pin), .low_rate_pin(low_rate_pin), .output_data_clock_phase(phase_out),
    .output_data_clock_invert(cfg_out[9]), .dco_delay_en(cfg_out[8]),
    .data_delay_en(cfg_out[7]), .fine_delay_code(cfg_out[6:4]),
    .user_pattern_one(pat_one), .user_pattern_two(pat_two), .overrange_pin_en(cfg_out[3]),
    .channel_core_sel(cfg_out[2]), .divider_sync_pulse_ff(pulse),
    .output_enable_bar_pin_en(cfg_out[1]), .low_rate_oscillator_on(osc_on),
    .sdio_pulldown_disable(cfg_out[0]));
  adcs_host i_adcs_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    chk("config outputs", cfg_out, 10'h00a);
    for (int i = 0; i < 12; i++) begin
      i_adcs_host.rd(addr_t[i], d);
      chk("reset value", d, rst_t[i]);
      i_adcs_host.wr(addr_t[i], 8'hff);
      i_adcs_host.rd(addr_t[i], d);
      chk("open bits", d, msk_t[i]);
    end
  endtask
  // config outputs with every writable bit set, then with features and misc cleared
  task automatic t_outputs;
    chk("config outputs", cfg_out, 10'h3ff);
    i_adcs_host.wr(9'h02a, 8'h00);
    i_adcs_host.wr(9'h101, 8'h00);
    chk("config outputs", cfg_out, 10'h3f4);
    sig_bit = 1'b1;
    repeat (2) @(posedge clk);
    i_adcs_host.rd(9'h024, d);
    chk("signature", d, 8'h01);
    sig_bit = 1'b0;
  endtask
  task automatic t_freeze;
    ce = 1'b0;
    i_adcs_host.wr(9'h019, 8'h5a);
    ce = 1'b1;
    chk("frozen pattern", pat_one, 16'h3ca5);
  endtask
  task automatic t_reset;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    chk("config outputs", cfg_out, 10'h00a);
    for (int i = 0; i < 12; i++) begin
      i_adcs_host.rd(addr_t[i], d);
      chk("reset value", d, rst_t[i]);
    end
  endtask
  task automatic t_pattern;
    i_adcs_host.wr(9'h019, 8'ha5);
    i_adcs_host.wr(9'h01a, 8'h3c);
    i_adcs_host.wr(9'h01b, 8'h0f);
    i_adcs_host.wr(9'h01c, 8'hf0);
    chk("pattern one", pat_one, 16'h3ca5);
    chk("pattern two", pat_two, 16'hf00f);
  endtask
  // code n adds n cycles to the one register stage that code zero already has
  task automatic t_phase;
    int cnt;
    for (int n = 0; n < 8; n++) begin
      i_adcs_host.wr(9'h016, 8'(n));
      @(posedge clk);
      #1;
      div_phase = 1'b1;
      cnt = 0;
      while (phase_out !== 1'b1 && cnt < 20) begin
        @(posedge clk);
        #1;
        cnt++;
      end
      div_phase = 1'b0;
      chk("phase delay", 16'(cnt), 16'(n + 1));
      repeat (12) @(posedge clk);
    end
  endtask
  task automatic t_sync(input logic [7:0] val, input int pulses, input logic [7:0] after);
    int cnt;
    cnt = 0;
    i_adcs_host.wr(9'h100, val);
    repeat (16) begin
      @(posedge clk);
      #1;
      sync_pin = (cnt % 8) < 3;
      cnt += 1 + 8 * pulse;
    end
    sync_pin = 1'b0;
    chk("sync pulses", 16'(cnt / 8 - 2), 16'(pulses));
    i_adcs_host.rd(9'h100, d);
    chk("sync control", d, after);
  endtask
  task automatic t_osc;
    i_adcs_host.wr(9'h101, 8'h88);
    repeat (4) @(posedge clk);
    #1;
    chk("oscillator idle", osc_on, 1'b0);
    low_rate_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("oscillator detect", osc_on, 1'b1);
    i_adcs_host.wr(9'h101, 8'h80);
    chk("detector off", osc_on, 1'b0);
    i_adcs_host.wr(9'h101, 8'h84);
    chk("oscillator forced", osc_on, 1'b1);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  // the whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    t_regs;
    t_outputs;
    t_pattern;
    t_freeze;
    t_phase;
    t_sync(8'h06, 0, 8'h06);
    t_sync(8'h01, 0, 8'h01);
    t_sync(8'h03, 2, 8'h03);
    t_sync(8'h07, 1, 8'h05);
    t_osc;
    t_reset;
    final_report;
  end
endmodule

// ==== adcs_host.sv ====
// host model driving the register port as the serial port engine would
`timescale 1ns/10ps
module adcs_host (
  // clock
  input  wire        clk,
  // register port
  output logic [8:0] reg_addr = 9'h000,
  output logic       reg_wr = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic       reg_rd = 1'b0,
  input  wire  [7:0] reg_rdata_ff
);
  // released lines are inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_ff;
  endtask
endmodule

// ==== adcs_phase_sel.v ====
// divider phase selection: delays the output clock phase by whole input cycles
`timescale 1ns/10ps
module adcs_phase_sel #(
  parameter DEPTH = 8
) (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  input  wire       ce,
  // divider phase in and phase choice
  input  wire       div_phase,
  input  wire [2:0] phase_sel,
  // chosen phase out
  output reg        phase_out_ff
);
  reg  [DEPTH-1:0] tap_ff;
  wire [DEPTH-1:0] nxt_tap;
  wire             nxt_phase_out;

  // ----------------------------------------------------------------------------
  // tap line: one stage per input cycle
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_tap
      if (g == 0) begin : g_first
        assign nxt_tap[g] = div_phase;
      end else begin : g_rest
        assign nxt_tap[g] = tap_ff[g-1];
      end
    end
  endgenerate

  // code 0 takes the undelayed phase, code n takes n stages of delay
  assign nxt_phase_out = (phase_sel == 3'h0) ? div_phase : tap_ff[phase_sel - 3'h1];

  always @(posedge clk) begin
    if (srst) begin
      tap_ff       <= {DEPTH{1'b0}};
      phase_out_ff <= 1'b0;
    end else if (ce) begin
      tap_ff       <= nxt_tap;
      phase_out_ff <= nxt_phase_out;
    end
  end
endmodule

// ==== adcs_regs.vh ====
// register offsets, field positions and reset values of the output and sync configuration bank
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define ADCS_OFS_CLK_PHASE   9'h016
`define ADCS_OFS_FINE_DELAY  9'h017
`define ADCS_OFS_PAT1_LO     9'h019
`define ADCS_OFS_PAT1_HI     9'h01a
`define ADCS_OFS_PAT2_LO     9'h01b
`define ADCS_OFS_PAT2_HI     9'h01c
`define ADCS_OFS_SIGNATURE   9'h024
`define ADCS_OFS_OVR_FEAT    9'h02a
`define ADCS_OFS_CH_ASSIGN   9'h02e
`define ADCS_OFS_SYNC_CTRL   9'h100
`define ADCS_OFS_USER_MISC   9'h101

// ----------------------------------------------------------------------------
// writable bit masks (open bits read zero)
// ----------------------------------------------------------------------------
`define ADCS_MSK_CLK_PHASE   8'h87
`define ADCS_MSK_FINE_DELAY  8'ha7
`define ADCS_MSK_ONE_BIT     8'h01
`define ADCS_MSK_SYNC_CTRL   8'h07
`define ADCS_MSK_USER_MISC   8'h8d

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ADCS_RST_ZERO        8'h00
`define ADCS_RST_OVR_FEAT    8'h01
`define ADCS_RST_SYNC_CTRL   8'h01
`define ADCS_RST_USER_MISC   8'h88

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ADCS_PHASE_MSB       2
`define ADCS_PHASE_LSB       0
`define ADCS_DCO_INV_BIT     7
`define ADCS_DLY_MSB         2
`define ADCS_DLY_LSB         0
`define ADCS_DLY_DATA_BIT    5
`define ADCS_DLY_DCO_BIT     7
`define ADCS_SYNC_MASTER_BIT 0
`define ADCS_SYNC_DIV_BIT    1
`define ADCS_SYNC_NEXT_BIT   2
`define ADCS_MISC_OEB_BIT    7
`define ADCS_MISC_DET_BIT    3
`define ADCS_MISC_RUN_BIT    2
`define ADCS_MISC_PD_BIT     0
`define ADCS_OVR_EN_BIT      0
`define ADCS_ASSIGN_BIT      0
`define ADCS_PHASE_CODES     8

`endif
